// ### design/cbt_bit_timing.sv
// can bit timing unit top: apb registers, bit segment sequencer, sampling, idle
// Summary of operation
// - each bit is a sync segment, then phase segment one, then phase segment two.
// - a recessive to dominant edge during interframe space hard-syncs the bit.
// - the sample point follows the programmed phase segment lengths.
// - the bus level is latched at the end of phase segment one.
// - one quantum lasts the prescaler division value in module clocks.
// - phase segment one is lengthened on a late edge to absorb phase error.
// - phase segment two is shortened on an early edge to absorb phase error.
// - a late correction never exceeds the programmed jump width; an early edge ends phase segment two at once.
// - bit times from 8 to 24 quanta are accepted; the reset values put the sample point at 75 percent.
// - interframe space covers intermission, suspend and idle as one recessive run.
// - a transmit start is allowed only while the bus is idle.
// - the prescaler divides by the field value plus one, field 0 to 1023.
// - bit rate is the module clock over prescale value plus one, times quanta per bit.
`timescale 1ns/1ns
module cbt_bit_timing #(
  parameter int PRESCALE_W = cbt_pkg::PRESCALE_W,
  parameter int IDLE_BITS = cbt_pkg::IDLE_BITS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic can_rx_i,
  output logic sample_strobe_o,
  output logic sample_bit_o,
  output logic bit_start_o,
  output logic bus_idle_o,
  output logic tx_start_o
);
  logic [PRESCALE_W-1:0] prescale;
  logic [cbt_pkg::SEG1_W-1:0] seg1_len;
  logic [cbt_pkg::SEG2_W-1:0] seg2_len;
  logic [cbt_pkg::SJW_W-1:0] sjw_len;
  logic config_mode;
  logic tx_req;
  logic [15:0] edge_count;
  logic tq_tick;
  logic rx_prev;
  logic sampled;
  cbt_pkg::cbt_seg_type seg_state;
  logic [5:0] seg_cnt;
  logic [5:0] seg1_target;
  logic [5:0] seg2_target;
  localparam int IDLE_CNT_W_L = cbt_pkg::IDLE_CNT_W;
  logic [IDLE_CNT_W_L-1:0] idle_cnt;
  logic [3:0] idle_bitq;
  logic fall_edge;
  logic hard_sync;
  logic resync;
  logic [5:0] phase_late;
  logic [5:0] phase_early;
  logic [5:0] jump;
  logic [5:0] corr_late;
  logic [5:0] corr_early;
  logic bit_end;
  logic apb_write;
  logic apb_read;
  logic [5:0] bit_total;
  logic cfg_ok;

  assign apb_write = psel_i && penable_i && pwrite_i;
  assign apb_read = psel_i && penable_i && !pwrite_i;
  assign bit_total = 6'(1) + 6'(seg1_len) + 6'(seg2_len);
  assign cfg_ok = (bit_total >= 6'(cbt_pkg::BIT_TQ_MIN))
    && (bit_total <= 6'(cbt_pkg::BIT_TQ_MAX));

  // register writes, timing fields only while in configuration
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prescale <= cbt_pkg::PRESCALE_RESET;
      seg1_len <= cbt_pkg::SEG1_RESET;
      seg2_len <= cbt_pkg::SEG2_RESET;
      sjw_len <= cbt_pkg::SJW_RESET;
      config_mode <= 1'b1;
    end
    else if (apb_write)
    begin
      if (paddr_i == cbt_pkg::ADDR_PRESCALE && config_mode)
        prescale <= pwdata_i[PRESCALE_W-1:0];
      if (paddr_i == cbt_pkg::ADDR_SEGMENTS && config_mode)
      begin
        seg1_len <= pwdata_i[cbt_pkg::SEG1_LSB +: cbt_pkg::SEG1_W];
        seg2_len <= pwdata_i[cbt_pkg::SEG2_LSB +: cbt_pkg::SEG2_W];
        sjw_len <= pwdata_i[cbt_pkg::SJW_LSB +: cbt_pkg::SJW_W];
      end
      if (paddr_i == cbt_pkg::ADDR_CONTROL)
        config_mode <= pwdata_i[cbt_pkg::CTRL_CONFIG_BIT];
    end
  end

  // apb answers: zero wait, error on unmapped address
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !(paddr_i == cbt_pkg::ADDR_PRESCALE
        || paddr_i == cbt_pkg::ADDR_SEGMENTS || paddr_i == cbt_pkg::ADDR_CONTROL
        || paddr_i == cbt_pkg::ADDR_STATUS || paddr_i == cbt_pkg::ADDR_EDGE_COUNT);
      prdata_o <= 32'h00000000;
      if (psel_i && !penable_i && !pwrite_i)
      begin
        unique case (paddr_i)
          cbt_pkg::ADDR_PRESCALE: prdata_o <= 32'(prescale);
          cbt_pkg::ADDR_SEGMENTS: prdata_o <= (32'(seg1_len) << cbt_pkg::SEG1_LSB)
            | (32'(seg2_len) << cbt_pkg::SEG2_LSB) | (32'(sjw_len) << cbt_pkg::SJW_LSB);
          cbt_pkg::ADDR_CONTROL: prdata_o <= 32'(config_mode) | (32'(tx_req) << 1);
          cbt_pkg::ADDR_STATUS: prdata_o <= (32'(bus_idle_o) << cbt_pkg::STAT_IDLE_BIT)
            | (32'(sampled) << cbt_pkg::STAT_SAMPLE_BIT)
            | (32'(tx_start_o) << cbt_pkg::STAT_TX_BIT)
            | (32'(config_mode) << cbt_pkg::STAT_CONFIG_BIT);
          cbt_pkg::ADDR_EDGE_COUNT: prdata_o <= 32'(edge_count);
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  cbt_quantum_gen #(
    .WIDTH(PRESCALE_W)
  ) u_quantum (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(config_mode),
    .divide_i(prescale),
    .tick_o(tq_tick)
  );

  // bus edge detection, edges seen on quantum ticks
  assign fall_edge = tq_tick && rx_prev && !can_rx_i;
  // hard sync only during interframe idle
  assign hard_sync = fall_edge && bus_idle_o;
  assign resync = fall_edge && !bus_idle_o && (seg_state != cbt_pkg::CBT_SYNC);
  assign jump = 6'(sjw_len);
  // phase error: late edge in seg1 counts quanta since sync, early edge in seg2
  assign phase_late = seg_cnt;
  assign phase_early = seg2_target - seg_cnt;
  // correction is min of error and jump
  assign corr_late = (phase_late < jump) ? phase_late : jump;
  assign corr_early = (phase_early < jump) ? phase_early : jump;
  assign bit_end = tq_tick && (seg_state == cbt_pkg::CBT_SEG2)
    && (seg_cnt + 6'd1 >= seg2_target);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rx_prev <= 1'b1;
    else if (tq_tick)
      rx_prev <= can_rx_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      seg_state <= cbt_pkg::CBT_SYNC;
      seg_cnt <= 6'd0;
      seg1_target <= 6'd0;
      seg2_target <= 6'd0;
    end
    else if (config_mode || !cfg_ok)
    begin
      seg_state <= cbt_pkg::CBT_SYNC;
      seg_cnt <= 6'd0;
    end
    else if (hard_sync)
    begin
      // edge marks sync segment just done, start seg1
      seg_state <= cbt_pkg::CBT_SEG1;
      seg_cnt <= 6'd0;
      seg1_target <= 6'(seg1_len);
      seg2_target <= 6'(seg2_len);
    end
    else if (tq_tick)
    begin
      unique case (seg_state)
        cbt_pkg::CBT_SYNC:
        begin
          seg_state <= cbt_pkg::CBT_SEG1;
          seg_cnt <= 6'd0;
          seg1_target <= 6'(seg1_len);
          seg2_target <= 6'(seg2_len);
        end
        cbt_pkg::CBT_SEG1:
        begin
          if (resync && seg1_target == 6'(seg1_len))
            seg1_target <= seg1_target + corr_late;
          // sample point set by seg lengths
          if (seg_cnt + 6'd1 >= seg1_target)
          begin
            seg_state <= cbt_pkg::CBT_SEG2;
            seg_cnt <= 6'd0;
          end
          else
            seg_cnt <= seg_cnt + 6'd1;
        end
        cbt_pkg::CBT_SEG2:
        begin
          if (resync)
          begin
            seg_state <= cbt_pkg::CBT_SEG1;
            seg_cnt <= 6'd0;
            seg1_target <= 6'(seg1_len);
            seg2_target <= 6'(seg2_len);
          end
          else if (bit_end)
          begin
            seg_state <= cbt_pkg::CBT_SYNC;
            seg_cnt <= 6'd0;
          end
          else
            seg_cnt <= seg_cnt + 6'd1;
        end
        default:
          seg_state <= cbt_pkg::CBT_SYNC;
      endcase
    end
  end

  // sample at seg1 to seg2 boundary
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sampled <= 1'b1;
      sample_strobe_o <= 1'b0;
      sample_bit_o <= 1'b1;
      bit_start_o <= 1'b0;
    end
    else
    begin
      sample_strobe_o <= 1'b0;
      bit_start_o <= 1'b0;
      if (!config_mode && cfg_ok && tq_tick && !hard_sync
        && seg_state == cbt_pkg::CBT_SEG1 && seg_cnt + 6'd1 >= seg1_target)
      begin
        sampled <= can_rx_i;
        sample_bit_o <= can_rx_i;
        sample_strobe_o <= 1'b1;
      end
      // one bit per prescale plus one times quanta
      if (!config_mode && cfg_ok && (hard_sync
        || (tq_tick && seg_state == cbt_pkg::CBT_SYNC)))
        bit_start_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      idle_cnt <= '0;
      bus_idle_o <= 1'b0;
      edge_count <= 16'h0000;
    end
    else if (config_mode)
    begin
      idle_cnt <= '0;
      bus_idle_o <= 1'b0;
    end
    else
    begin
      if (sample_strobe_o)
      begin
        if (!sample_bit_o)
        begin
          idle_cnt <= '0;
          bus_idle_o <= 1'b0;
        end
        else if (32'(idle_cnt) + 1 >= IDLE_BITS)
          bus_idle_o <= 1'b1;
        else
          idle_cnt <= idle_cnt + 1'b1;
      end
      if (hard_sync)
        bus_idle_o <= 1'b0;
      if (fall_edge)
        edge_count <= edge_count + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_req <= 1'b0;
      tx_start_o <= 1'b0;
    end
    else
    begin
      tx_start_o <= 1'b0;
      if (tx_req && bus_idle_o && bit_start_o)
      begin
        tx_start_o <= 1'b1;
        tx_req <= 1'b0;
      end
      else if (apb_write && paddr_i == cbt_pkg::ADDR_CONTROL)
        tx_req <= pwdata_i[cbt_pkg::CTRL_TX_REQ_BIT] && !pwdata_i[cbt_pkg::CTRL_CONFIG_BIT];
    end
  end
endmodule

// ### common/cbt_pkg.sv
// package of register map, field layouts and timing constants for the can bit timing unit
package cbt_pkg;
  // apb register byte addresses
  localparam logic [7:0] ADDR_PRESCALE = 8'h00;
  localparam logic [7:0] ADDR_SEGMENTS = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_EDGE_COUNT = 8'h10;
  // field widths
  localparam int PRESCALE_W = 10;
  localparam int SEG1_W = 5;
  localparam int SEG2_W = 4;
  localparam int SJW_W = 3;
  // segment register field positions
  localparam int SEG1_LSB = 0;
  localparam int SEG2_LSB = 8;
  localparam int SJW_LSB = 16;
  // control bit positions
  localparam int CTRL_CONFIG_BIT = 0;
  localparam int CTRL_TX_REQ_BIT = 1;
  // status bit positions
  localparam int STAT_IDLE_BIT = 0;
  localparam int STAT_SAMPLE_BIT = 1;
  localparam int STAT_TX_BIT = 2;
  localparam int STAT_CONFIG_BIT = 3;
  // reset values: 8 tq bit at 75 percent, divide by one
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 10'h000;
  localparam logic [SEG1_W-1:0] SEG1_RESET = 5'h05;
  localparam logic [SEG2_W-1:0] SEG2_RESET = 4'h2;
  localparam logic [SJW_W-1:0] SJW_RESET = 3'h1;
  // supported bit time range in quanta
  localparam int BIT_TQ_MIN = 8;
  localparam int BIT_TQ_MAX = 24;
  // recessive bits that make up intermission plus idle detect
  localparam int IDLE_BITS = 11;
  localparam int IDLE_CNT_W = 4;
  // bit segment states
  typedef enum logic [1:0] {CBT_SYNC, CBT_SEG1, CBT_SEG2} cbt_seg_type;
endpackage

// ### design/cbt_quantum_gen.sv
// quantum tick generator dividing the module clock by prescaler value plus one
`timescale 1ns/1ns
module cbt_quantum_gen #(
  parameter int WIDTH = 10
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic restart_i,
  input wire logic [WIDTH-1:0] divide_i,
  output logic tick_o
);
  logic [WIDTH-1:0] count;

  // down count from programmed value, tick on wrap
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count <= '0;
      tick_o <= 1'b0;
    end
    else if (restart_i)
    begin
      count <= divide_i;
      tick_o <= 1'b0;
    end
    else if (count == '0)
    begin
      count <= divide_i;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count - 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ### verification/cbt_bit_timing_monitor.sv
// assertion checker on the bit timing unit ports
`timescale 1ns/1ns
module cbt_bit_timing_monitor #(
  parameter int PRESCALE_W = 10,
  parameter int IDLE_BITS = 11
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic can_rx_i,
  input wire logic sample_strobe_o,
  input wire logic sample_bit_o,
  input wire logic bit_start_o,
  input wire logic bus_idle_o,
  input wire logic tx_start_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // apb phases
  sequence apb_setup;
    psel_i && !penable_i;
  endsequence
  sequence apb_access;
    psel_i && penable_i && pready_o;
  endsequence
  // bus handshake
  a_apb_answer: assert property (apb_setup |=> apb_access)
    else $error("no answer in access phase");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_error_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // bit segment sequencing
  a_strobe_pulse: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe too long");
  a_sync_apart: assert property (bit_start_o |-> !sample_strobe_o)
    else $error("sample point inside sync");
  a_start_pulse: assert property (bit_start_o |=> !bit_start_o)
    else $error("bit start too long");
  a_sample_hold: assert property ($changed(sample_bit_o) |-> sample_strobe_o)
    else $error("bit value moved off sample point");
  a_idle_recessive: assert property ($rose(bus_idle_o) |-> sample_bit_o)
    else $error("idle on dominant sample");
  // grant is registered one cycle after the bit start it was taken on
  a_tx_idle_only: assert property (tx_start_o |-> $past(bit_start_o) && $past(bus_idle_o))
    else $error("transmit start while busy");
endmodule

// ### verification/cbt_can_node.sv
// behavioural remote can node driving the receive line
`timescale 1ns/1ns
module cbt_can_node (
  input wire logic clk_i,
  output logic can_rx_o
);
  // recessive bus while no frame
  initial can_rx_o = 1'b1;
  task automatic send(input logic [7:0] bits, input int clocks);
    int i;
    int k;
    for (i = 7; i >= 0; i--)
    begin
      can_rx_o <= bits[i];
      for (k = 0; k < clocks; k++)
        @(posedge clk_i);
    end
    can_rx_o <= 1'b1;
  endtask
endmodule

// ### verification/cbt_bit_timing_tb_top.sv
// self-checking bench for the can bit timing unit
`timescale 1ns/1ns
module cbt_bit_timing_tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, sample_strobe_o, sample_bit_o, bit_start_o, bus_idle_o, tx_start_o;
  wire logic can_rx_i;
  logic [31:0] rd;
  logic err;
  logic [7:0] got;
  int fails = 0;
  int check_count = 0;
  int seed = 51139;
  int cyc = 0;
  int p, s1, s2, sg, t0, t1, n, k;
  // event lines: 0 bit start, 1 strobe, 2 idle, 3 tx start, 4 ready
  logic [4:0] ev;
  logic bit_start_q = 1'b0;
  assign ev = {pready_o, tx_start_o, bus_idle_o, sample_strobe_o, bit_start_o};
  always #20 clk_i = ~clk_i;
  // bit start delayed one cycle, to line up with the registered grant
  always @(posedge clk_i)
    bit_start_q <= bit_start_o;
  // cycle count for timing checks
  always @(posedge clk_i)
    cyc <= cyc + 1;
  cbt_bit_timing cbt_bit_timing_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .can_rx_i(can_rx_i),
    .sample_strobe_o(sample_strobe_o), .sample_bit_o(sample_bit_o),
    .bit_start_o(bit_start_o), .bus_idle_o(bus_idle_o), .tx_start_o(tx_start_o));
  cbt_can_node cbt_can_node_inst (.clk_i(clk_i), .can_rx_o(can_rx_i));
  task automatic test_done();
    $display("compares %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, g, e);
    end
  endtask
  // wait on one event line, bounded
  task automatic wait_for(input int w);
    int i;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end while (ev[w] !== 1'b1 && i < 9000);
    if (i >= 9000)
    begin
      chk(32'h0, 32'h1, "wait ran out");
      test_done();
    end
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    wait_for(4);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic logic [31:0] segs(input int a, input int b);
    return 32'h00010000 | (b << 8) | a;
  endfunction
  initial
  begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, cbt_pkg::ADDR_SEGMENTS, 32'h0);
    chk(rd, segs(5, 2), "segment reset");
    apb(1'b0, cbt_pkg::ADDR_CONTROL, 32'h0);
    chk(rd, 32'h1, "control reset");
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    for (n = 0; n < 4; n++)
    begin
      p = $unsigned($random(seed)) % 3;
      s1 = 5 + $unsigned($random(seed)) % 10;
      s2 = 2 + $unsigned($random(seed)) % 5;
      apb(1'b1, cbt_pkg::ADDR_CONTROL, 32'h1);
      apb(1'b1, cbt_pkg::ADDR_PRESCALE, p);
      apb(1'b1, cbt_pkg::ADDR_SEGMENTS, segs(s1, s2));
      apb(1'b1, cbt_pkg::ADDR_CONTROL, 32'h0);
      apb(1'b1, cbt_pkg::ADDR_SEGMENTS, 32'h00000909);
      apb(1'b0, cbt_pkg::ADDR_SEGMENTS, 32'h0);
      chk(rd, segs(s1, s2), "segments locked");
      wait_for(0);
      t0 = cyc;
      wait_for(1);
      t1 = cyc;
      // bit start marks the end of the sync quantum, strobe ends phase segment one
      sg = s1 * (p + 1);
      chk(t1 - t0 >= sg - 1 && t1 - t0 <= sg + 1, 1, "sample point");
      wait_for(1);
      chk(cyc - t1, (1 + s1 + s2) * (p + 1), "bit period");
    end
    apb(1'b1, cbt_pkg::ADDR_CONTROL, 32'h1);
    apb(1'b1, cbt_pkg::ADDR_PRESCALE, 32'h0);
    apb(1'b1, cbt_pkg::ADDR_SEGMENTS, segs(5, 4));
    apb(1'b1, cbt_pkg::ADDR_CONTROL, 32'h0);
    repeat (10) wait_for(1);
    chk(bus_idle_o, 1'b0, "idle too early");
    repeat (2) wait_for(1);
    chk(bus_idle_o, 1'b1, "idle missing");
    apb(1'b1, cbt_pkg::ADDR_CONTROL, 32'h2);
    wait_for(3);
    chk(bit_start_q, 1'b1, "tx start off bit");
    // slow remote node, resync must keep lock
    wait_for(1);
    fork
      cbt_can_node_inst.send(8'h55, 11);
      for (k = 7; k >= 0; k--)
      begin
        wait_for(1);
        got[k] = sample_bit_o;
      end
    join
    chk(got, 8'h55, "resync bits");
    // four recessive to dominant edges in the frame
    apb(1'b0, cbt_pkg::ADDR_EDGE_COUNT, 32'h0);
    chk(rd, 32'h4, "falling edges");
    test_done();
  end
endmodule
bind cbt_bit_timing cbt_bit_timing_monitor #(.PRESCALE_W(PRESCALE_W), .IDLE_BITS(IDLE_BITS))
  cbt_bit_timing_monitor_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .can_rx_i(can_rx_i),
  .sample_strobe_o(sample_strobe_o), .sample_bit_o(sample_bit_o),
  .bit_start_o(bit_start_o), .bus_idle_o(bus_idle_o), .tx_start_o(tx_start_o));
